// ### osil_host_model.sv
// osil_host_model.sv - link side reader of the interrupt latch
`timescale 1ns/10ps
module osil_host_model (
   // link clock
   input wire logic clk_link_i,
   // answer from the block
   input wire logic latch_valid_i,
   input wire logic [2:0] latch_data_i,
   // read request
   output logic latch_rd_o
);
   // request is held until the answer is seen; a hang returns unknown data
   task automatic read(input int gap, output logic [2:0] d);
      int n;
      n = 0;
      repeat (gap) @(posedge clk_link_i);
      #2 latch_rd_o = 1'b1;
      do begin
         @(posedge clk_link_i);
         n++;
      end while (latch_valid_i !== 1'b1 && n < 40);
      d = (n < 40) ? latch_data_i : 3'bxxx;
      #2 latch_rd_o = 1'b0;
      // one idle cycle before the next request
      @(posedge clk_link_i);
   endtask : read
   initial latch_rd_o = 1'b0;
endmodule : osil_host_model

// ### osil_params.svh
// osil_params.svh - constants for the otg status and interrupt logic
`ifndef OSIL_PARAMS_SVH
`define OSIL_PARAMS_SVH
// ***********************************************************
// status and latch bit positions
// ***********************************************************
`define OSIL_BIT_PWR_GOOD 0
`define OSIL_BIT_ACTIVE 1
`define OSIL_BIT_IDLE 2
`define OSIL_NUM_SRC 3
// ***********************************************************
// reset values
// ***********************************************************
`define OSIL_RST_OPEN_DRAIN 1'b1
`define OSIL_RST_LATCH 3'h0
// ***********************************************************
// slave address: base plus slot select in lsb (arbitrary base)
// ***********************************************************
`define OSIL_ADDR_BASE 7'h2C
`endif

// ### osil_pkg.sv
// osil_pkg.sv - types for the otg status and interrupt logic
package osil_pkg;
   // link side read handshake state
   typedef enum logic [1:0] {
      OSIL_RD_IDLE,
      OSIL_RD_WAIT,
      OSIL_RD_DONE
   } osil_rd_e;
endpackage : osil_pkg

// ### osil_top.sv
// osil_top.sv - status flags, edge-selected interrupt latch and role echo
`timescale 1ns/10ps
`include "osil_params.svh"
module osil_top (
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link clock for the latch read handshake
   input wire logic clk_link_i,
   // comparator outputs (asynchronous)
   input wire logic cmp_pwr_good_i,
   input wire logic cmp_active_i,
   input wire logic cmp_idle_i,
   // role and slot pins (asynchronous)
   input wire logic role_pin_in_i,
   input wire logic slot_sel_i,
   // configuration from the register side
   input wire logic cfg_open_drain_i,
   input wire logic [2:0] int_mask_i,
   input wire logic [1:0] int_rise_i,
   input wire logic dp_pullup_i,
   input wire logic dm_pullup_i,
   input wire logic dp_pulldown_i,
   input wire logic dm_pulldown_i,
   input wire logic vbus_chg_pulse_i,
   input wire logic vbus_chg_cont_i,
   input wire logic vbus_drive_i,
   input wire logic vbus_dischg_i,
   // latch read request, link domain
   input wire logic latch_rd_i,
   // latch, link domain; status, role level and address, system domain
   output logic [2:0] status_o,
   output logic [2:0] latch_data_o,
   output logic latch_valid_o,
   output logic role_level_o,
   output logic [6:0] slave_addr_o,
   // attention pin
   output logic attn_n_o,
   output logic attn_oe_o,
   // role echo and analog switch controls
   output logic role_pin_echo_o,
   output logic dp_pullup_o,
   output logic dm_pullup_o,
   output logic dp_pulldown_o,
   output logic dm_pulldown_o,
   output logic vbus_chg_pulse_o,
   output logic vbus_chg_cont_o,
   output logic vbus_drive_o,
   output logic vbus_dischg_o
);
   // ***********************************************************
   // pin synchronisers (system domain)
   // ***********************************************************
   logic [4:0] pin_s1; // first stage, read only by second stage
   logic [4:0] pin_s2; // usable levels
   logic [2:0] flag_prev; // previous flags for edge detect
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1 <= 5'h00;
         pin_s2 <= 5'h00;
      end else begin
         pin_s1 <= {slot_sel_i, role_pin_in_i, cmp_idle_i, cmp_active_i, cmp_pwr_good_i};
         pin_s2 <= pin_s1;
      end
   end
   wire [2:0] flag = pin_s2[2:0];
   // ***********************************************************
   // edge qualification
   // ***********************************************************
   // edges are ignored until the synchroniser and flag_prev hold real pin levels;
   // otherwise a pin that is high at reset would look like a rising edge
   logic [2:0] warm; // fills with ones over the first three edges after reset
   wire armed = warm[2];
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         warm <= 3'h0;
      end else begin
         warm <= {warm[1:0], 1'b1};
      end
   end
   wire [2:0] rise = flag & ~flag_prev & {3{armed}};
   wire [2:0] fall = ~flag & flag_prev & {3{armed}};
   wire [2:0] qual;
   // chosen edge of one flag: rising when pick_rise is set, else falling
   function automatic logic edge_pick(input logic pick_rise, input logic up, input logic down);
      return pick_rise ? up : down;
   endfunction : edge_pick
   // power good and link active pick their edge
   assign qual[`OSIL_BIT_PWR_GOOD] = edge_pick(int_rise_i[0], rise[0], fall[0]);
   assign qual[`OSIL_BIT_ACTIVE] = edge_pick(int_rise_i[1], rise[1], fall[1]);
   // idle flag rises when vbus falls below the idle level
   assign qual[`OSIL_BIT_IDLE] = rise[2];
   wire [2:0] event_set = qual & int_mask_i;
   // ***********************************************************
   // latch read crossing: toggle from link, ack toggle back
   // ***********************************************************
   logic rd_tgl_l; // link domain request toggle
   logic [2:0] rd_sync; // system side sync of toggle, [0] is first stage
   logic [2:0] latch; // captured events
   logic [2:0] snap; // value handed to the link, held stable
   logic ack_tgl; // system side acknowledge toggle
   wire rd_req = rd_sync[2] ^ rd_sync[1];
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rd_sync <= 3'h0;
      end else begin
         rd_sync <= {rd_sync[1:0], rd_tgl_l};
      end
   end
   // set wins over the clear of a read in the same cycle
   wire [2:0] next_latch = (rd_req ? 3'h0 : latch) | event_set;
   // snap and the ack toggle change in the same cycle and snap then holds until the
   // next request, so the link side may take all three bits once it sees the ack
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         latch <= `OSIL_RST_LATCH;
         flag_prev <= 3'h0;
         snap <= 3'h0;
         ack_tgl <= 1'b0;
      end else begin
         latch <= next_latch;
         flag_prev <= flag;
         if (rd_req) begin
            snap <= latch;
            ack_tgl <= ~ack_tgl;
         end
      end
   end
   // ***********************************************************
   // attention output
   // ***********************************************************
   logic attn; // held while any latch bit set
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         attn <= 1'b0;
      end else begin
         attn <= |next_latch;
      end
   end
   // drive mode is registered so the pin is open drain straight out of reset,
   // whatever the configuration port shows at that time
   logic drive_od;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         drive_od <= `OSIL_RST_OPEN_DRAIN;
      end else begin
         drive_od <= cfg_open_drain_i;
      end
   end
   // open drain drives only the low level
   assign attn_n_o = ~attn;
   assign attn_oe_o = drive_od ? attn : 1'b1;
   // ***********************************************************
   // link domain: request and return of latch contents
   // ***********************************************************
   logic [1:0] ack_sync; // [0] first stage
   logic ack_seen;
   // a request seen while a read is under way is ignored; the host holds its
   // request until the answer and drops it before the idle state samples it again
   osil_pkg::osil_rd_e rd_st;
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         ack_sync <= 2'h0;
      end else begin
         ack_sync <= {ack_sync[0], ack_tgl};
      end
   end
   always_ff @(posedge clk_link_i or posedge rst_i) begin
      if (rst_i) begin
         rd_st <= osil_pkg::OSIL_RD_IDLE;
         rd_tgl_l <= 1'b0;
         ack_seen <= 1'b0;
         latch_data_o <= 3'h0;
         latch_valid_o <= 1'b0;
      end else begin
         latch_valid_o <= 1'b0;
         case (rd_st)
            osil_pkg::OSIL_RD_IDLE: begin
               if (latch_rd_i) begin
                  rd_tgl_l <= ~rd_tgl_l;
                  rd_st <= osil_pkg::OSIL_RD_WAIT;
               end
            end
            osil_pkg::OSIL_RD_WAIT: begin
               if (ack_sync[1] != ack_seen) begin
                  ack_seen <= ack_sync[1];
                  latch_data_o <= snap; // stable: changed in the same cycle as the ack toggle
                  latch_valid_o <= 1'b1;
                  rd_st <= osil_pkg::OSIL_RD_DONE;
               end
            end
            osil_pkg::OSIL_RD_DONE: begin
               rd_st <= osil_pkg::OSIL_RD_IDLE;
            end
            default: begin
               rd_st <= osil_pkg::OSIL_RD_IDLE;
            end
         endcase
      end
   end
   // ***********************************************************
   // status, role echo, address and switch controls
   // ***********************************************************
   // base address as a vector, so that its upper six bits can be sliced
   wire [6:0] addr_base = `OSIL_ADDR_BASE;
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         status_o <= 3'h0;
         role_level_o <= 1'b0;
         role_pin_echo_o <= 1'b0;
         slave_addr_o <= `OSIL_ADDR_BASE;
         {dp_pullup_o, dm_pullup_o, dp_pulldown_o, dm_pulldown_o} <= 4'h0;
         {vbus_chg_pulse_o, vbus_chg_cont_o, vbus_drive_o, vbus_dischg_o} <= 4'h0;
      end else begin
         status_o <= flag;
         role_level_o <= pin_s2[3];
         role_pin_echo_o <= pin_s2[3];
         // unconnected slot input reads low, giving the base address
         slave_addr_o <= {addr_base[6:1], pin_s2[4]};
         {dp_pullup_o, dm_pullup_o, dp_pulldown_o, dm_pulldown_o} <=
            {dp_pullup_i, dm_pullup_i, dp_pulldown_i, dm_pulldown_i};
         {vbus_chg_pulse_o, vbus_chg_cont_o, vbus_drive_o, vbus_dischg_o} <=
            {vbus_chg_pulse_i, vbus_chg_cont_i, vbus_drive_i, vbus_dischg_i};
      end
   end
   // ***********************************************************
   // assertions
   // ***********************************************************
   property p_attn_cause;
      @(posedge clk_sys_i) disable iff (rst_i) $rose(attn) |-> $past(|event_set);
   endproperty
   a_attn_cause: assert property (p_attn_cause) else $error("attention without event");
   property p_attn_hold;
      @(posedge clk_sys_i) disable iff (rst_i) attn && !rd_req && !(|event_set) |=> attn;
   endproperty
   a_attn_hold: assert property (p_attn_hold) else $error("attention dropped early");
   property p_set_latch;
      @(posedge clk_sys_i) disable iff (rst_i) |event_set |=> (latch & $past(event_set)) != 3'h0;
   endproperty
   a_set_latch: assert property (p_set_latch) else $error("event not latched");
   property p_rd_clear;
      @(posedge clk_sys_i) disable iff (rst_i) rd_req && !(|event_set) |=> latch == 3'h0;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");
   property p_drive;
      @(posedge clk_sys_i) disable iff (rst_i) !attn |-> (drive_od ? !attn_oe_o : attn_n_o);
   endproperty
   a_drive: assert property (p_drive) else $error("attention drive wrong");
   property p_echo;
      @(posedge clk_sys_i) disable iff (rst_i) ##1 role_pin_echo_o == $past(pin_s2[3]);
   endproperty
   a_echo: assert property (p_echo) else $error("role echo wrong");
   property p_addr;
      @(posedge clk_sys_i) disable iff (rst_i) ##1 slave_addr_o[0] == $past(pin_s2[4]);
   endproperty
   a_addr: assert property (p_addr) else $error("address lsb wrong");
   property p_idle;
      @(posedge clk_sys_i) disable iff (rst_i) rise[2] && int_mask_i[2] |=> latch[2];
   endproperty
   a_idle: assert property (p_idle) else $error("idle entry not latched");
   property p_pwr;
      @(posedge clk_sys_i) disable iff (rst_i) fall[0] && !int_rise_i[0] && int_mask_i[0] |=> latch[0];
   endproperty
   a_pwr: assert property (p_pwr) else $error("power good fall missed");
   property p_act;
      @(posedge clk_sys_i) disable iff (rst_i) rise[1] && int_rise_i[1] && int_mask_i[1] |=> latch[1];
   endproperty
   a_act: assert property (p_act) else $error("active rise missed");
   property p_oe_push;
      @(posedge clk_sys_i) disable iff (rst_i) !drive_od |-> attn_oe_o;
   endproperty
   a_oe_push: assert property (p_oe_push) else $error("push-pull not driving");
   property p_status;
      @(posedge clk_sys_i) disable iff (rst_i) ##1 status_o == $past(flag);
   endproperty
   a_status: assert property (p_status) else $error("status flags wrong");
   property p_rd_snap;
      @(posedge clk_sys_i) disable iff (rst_i) rd_req |=> snap == $past(latch);
   endproperty
   a_rd_snap: assert property (p_rd_snap) else $error("read snapshot wrong");
   property p_set_wins;
      @(posedge clk_sys_i) disable iff (rst_i)
         rd_req && (|event_set) |=> (latch & $past(event_set)) == $past(event_set);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost in read cycle");
   property p_valid_pulse;
      @(posedge clk_link_i) disable iff (rst_i) latch_valid_o |=> !latch_valid_o;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("valid not one cycle");
   c_push: cover property (@(posedge clk_sys_i) disable iff (rst_i) attn && !drive_od);
   c_idle: cover property (@(posedge clk_sys_i) disable iff (rst_i) event_set[2]);
   c_attn: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(attn));
   c_clear: cover property (@(posedge clk_sys_i) disable iff (rst_i) $fell(attn));
   c_rd: cover property (@(posedge clk_link_i) disable iff (rst_i) latch_valid_o && latch_data_o != 3'h0);
endmodule : osil_top

// ### testbench.sv
// testbench.sv - self-checking bench for the otg status and interrupt logic
`timescale 1ns/10ps
`include "osil_params.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   // ****
   // clocks, pins and counters
   // ****
   logic clk_sys_i = 1'b0;
   logic clk_link_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] cmp = 3'h4; // bus low: only the idle flag true
   logic role = 1'b0;
   logic slot = 1'b0;
   logic od = 1'b0; // push-pull asked during reset; the pin must still be open drain
   logic [2:0] mask = 3'h0;
   logic [1:0] rise = 2'h0;
   logic [7:0] sw = 8'h00;
   logic [7:0] sw_o;
   logic [2:0] status;
   logic [2:0] ldata;
   logic lvalid, lrd, role_lvl, attn_n, attn_oe, echo;
   logic [6:0] addr;
   int n_errors = 0;
   int samples_checked = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   // link clock offset so its edges never line up with the system clock
   initial begin
      #3;
      forever #80 clk_link_i = ~clk_link_i;
   end
   osil_top u_osil_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i),
      .cmp_pwr_good_i(cmp[0]), .cmp_active_i(cmp[1]), .cmp_idle_i(cmp[2]),
      .role_pin_in_i(role), .slot_sel_i(slot), .cfg_open_drain_i(od),
      .int_mask_i(mask), .int_rise_i(rise), .dp_pullup_i(sw[0]), .dm_pullup_i(sw[1]),
      .dp_pulldown_i(sw[2]), .dm_pulldown_i(sw[3]), .vbus_chg_pulse_i(sw[4]),
      .vbus_chg_cont_i(sw[5]), .vbus_drive_i(sw[6]), .vbus_dischg_i(sw[7]),
      .latch_rd_i(lrd), .status_o(status), .latch_data_o(ldata), .latch_valid_o(lvalid),
      .role_level_o(role_lvl), .slave_addr_o(addr), .attn_n_o(attn_n), .attn_oe_o(attn_oe),
      .role_pin_echo_o(echo), .dp_pullup_o(sw_o[0]), .dm_pullup_o(sw_o[1]),
      .dp_pulldown_o(sw_o[2]), .dm_pulldown_o(sw_o[3]), .vbus_chg_pulse_o(sw_o[4]),
      .vbus_chg_cont_o(sw_o[5]), .vbus_drive_o(sw_o[6]), .vbus_dischg_o(sw_o[7]));
   osil_host_model u_osil_host_model (.clk_link_i(clk_link_i), .latch_valid_i(lvalid),
      .latch_data_i(ldata), .latch_rd_o(lrd));
   // ****
   // shared helpers
   // ****
   // scenario inputs change 2 ns after a system edge; the read request 2 ns after a link edge
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #2;
   endtask : step
   task automatic rd(input logic [2:0] e);
      logic [2:0] d;
      u_osil_host_model.read(1, d);
      `CHK(d, e)
      step(4);
   endtask : rd
   // bounded wait, long enough to also catch a late spurious assertion
   task automatic attn_wait(input logic low);
      int n;
      n = 0;
      while (attn_n !== 1'b0 && n < 16) begin
         step(1);
         n++;
      end
      `CHK(attn_n, ~low)
      `CHK(attn_oe, od ? low : 1'b1)
   endtask : attn_wait
   // ****
   // scenarios
   // ****
   task automatic t_reset();
      `CHK(attn_n, 1'b1)
      `CHK(attn_oe, 1'b0)
      `CHK(addr, `OSIL_ADDR_BASE)
      step(6);
      `CHK(status, 3'h4)
      $display("reset test done");
   endtask : t_reset
   // toggles one flag away and back; exactly one of the two edges may fire
   task automatic t_edge(input int b, input logic r);
      logic v;
      logic f;
      mask = 3'h1 << b;
      if (b < 2) rise[b] = r;
      repeat (2) begin
         v = ~cmp[b];
         cmp[b] = v;
         f = (b == 2) ? v : (v == r);
         step(6);
         `CHK(status[b], v)
         attn_wait(f);
         rd(f ? mask : 3'h0);
         `CHK(attn_n, 1'b1)
      end
      $display("edge test bit %0d done", b);
   endtask : t_edge
   task automatic t_multi();
      mask = 3'h0;
      rise = 2'h3;
      cmp[0] = 1'b1;
      attn_wait(1'b0);
      rd(3'h0);
      mask = 3'h3;
      cmp[1] = 1'b0;
      step(20);
      cmp[1] = 1'b1;
      cmp[0] = 1'b0;
      step(20);
      cmp[0] = 1'b1;
      attn_wait(1'b1);
      rd(3'h3);
      rd(3'h0);
      od = 1'b0;
      attn_wait(1'b0);
      // push-pull while asserted: idle entry with only the idle bit enabled
      mask = 3'h4;
      cmp[2] = 1'b0;
      step(8);
      cmp[2] = 1'b1;
      attn_wait(1'b1);
      rd(3'h4);
      od = 1'b1;
      $display("mask and multi test done");
   endtask : t_multi
   task automatic t_pins();
      for (int v = 0; v < 2; v++) begin
         role = v[0];
         slot = v[0];
         sw = v[0] ? 8'hA5 : 8'h5A;
         step(6);
         `CHK(echo, v[0])
         `CHK(role_lvl, v[0])
         `CHK(addr, `OSIL_ADDR_BASE | {6'h00, v[0]})
         `CHK(sw_o, sw)
      end
      $display("pin test done");
   endtask : t_pins
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // watchdog: the tests need about 22 us, so this leaves a wide margin
   initial begin
      #200_000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      // reset must leave the pin open drain even though the port asks for push-pull
      `CHK(attn_oe, 1'b0)
      #2 rst_i = 1'b0;
      od = 1'b1;
      step(2);
      t_reset();
      for (int b = 0; b < 2; b++) begin
         for (int r = 0; r < 2; r++) begin
            t_edge(b, r[0]);
         end
      end
      t_edge(2, 1'b1);
      t_multi();
      t_pins();
      finish_test();
   end
endmodule : testbench
